// ### src/usc_pkg.sv
// Package of the USB status and control block: register indices, field
// positions, reset values and the packed carriers shared by its modules.
// Assumes a single module clock and a synchronous active-high reset.
//
// Notes on behaviour
// - Status window valid only while token-done set.
// - Four-entry queue holds completed transaction status.
// - Engine finishing a descriptor pushes one entry.
// - Clearing token-done presents next entry, re-raises flag.
// - Status bits 7-4 hold endpoint number 0-15.
// - Status bit 3 is one for IN transfers.
// - Status bit 2 is one for odd bank.
// - Setup token sets hold bit, stops packets.
// - Software clears hold; token processing then resumes.
// - Resume bit set drives remote wakeup signalling.
// - Writing bank-clear bit zeroes ping-pong bank bits.
// - Bank clear touches only endpoints five, six.
// - Enable set starts module, resets bank bits.
// - Accept tokens only matching seven-bit address.
// - Address cleared by reset and bus reset.
// - Every start-of-frame loads eleven-bit frame number.
// - High register bits 2-0 hold frame 10-8.
`default_nettype none

package usc_pkg;

    // ------------------------------------------------------------------
    // Register indices on the register port.
    // ------------------------------------------------------------------
    localparam logic [2:0] REG_STATUS    = 3'h0;
    localparam logic [2:0] REG_CONTROL   = 3'h1;
    localparam logic [2:0] REG_ADDRESS   = 3'h2;
    localparam logic [2:0] REG_FRAME_LOW = 3'h3;
    localparam logic [2:0] REG_FRAME_HI  = 3'h4;

    // ------------------------------------------------------------------
    // Field positions and reset values.
    // ------------------------------------------------------------------
    localparam int unsigned CTL_HOLD_BIT   = 5;
    localparam int unsigned CTL_RESUME_BIT = 2;
    localparam int unsigned CTL_BANKCLR_BIT = 1;
    localparam int unsigned CTL_ENABLE_BIT = 0;
    localparam logic [7:0]  CTL_RESET      = 8'h00;
    localparam logic [6:0]  ADDRESS_RESET  = 7'h00;
    localparam logic [10:0] FRAME_RESET    = 11'h000;
    localparam int unsigned QUEUE_DEPTH    = 4;
    localparam logic [2:0]  QUEUE_FULL_CNT = 3'h4;

    // ------------------------------------------------------------------
    // Carriers.
    // ------------------------------------------------------------------
    // One completed transaction as the engine reports it.
    typedef struct packed {
        logic [3:0] endpoint;
        logic       dir_in;
        logic       odd_bank;
    } usc_status_t;

    // One access on the register port; rd and wr are one-cycle strobes.
    typedef struct packed {
        logic [2:0] index;
        logic       rd;
        logic       wr;
        logic [7:0] wdata;
    } usc_reg_req_t;

    // A decoded token header from the serial engine.
    typedef struct packed {
        logic       valid;
        logic [6:0] address;
    } usc_token_t;

    // A received start-of-frame token.
    typedef struct packed {
        logic        valid;
        logic [10:0] frame;
    } usc_sof_t;

    // Status entry laid out as the status window byte.
    function automatic logic [7:0] usc_status_byte(input usc_status_t s);
        usc_status_byte = {s.endpoint, s.dir_in, s.odd_bank, 2'b00};
    endfunction

endpackage

`default_nettype wire

// ### src/usc_status_mem.sv
// Four-word memory that holds queued transaction status entries.
// Assumes the owner keeps its own pointers; read data are registered.
`default_nettype none

module usc_status_mem
    import usc_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        ce,
    input  wire logic        wr_en,
    input  wire logic [1:0]  wr_addr,
    input  wire usc_status_t wr_data,
    input  wire logic [1:0]  rd_addr,
    output usc_status_t      rd_data
);

    usc_status_t mem [QUEUE_DEPTH];

    // ------------------------------------------------------------------
    // Storage.
    // ------------------------------------------------------------------
    // Read before write: a word written this cycle is seen one cycle later.
    always_ff @(posedge mclk) begin
        if (ce) begin
            if (wr_en) begin
                mem[wr_addr] <= wr_data;
            end
            rd_data <= mem[rd_addr];
        end
    end

endmodule

`default_nettype wire

// ### src/usc_addr_frame.sv
// Device address register, token address match and frame number capture.
// Assumes token and frame inputs come from logic on the module clock.
`default_nettype none

module usc_addr_frame
    import usc_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic        ce,
    input  wire logic        addr_wr,
    input  wire logic [6:0]  addr_wdata,
    input  wire logic        bus_reset_det,
    input  wire logic        module_enable,
    input  wire logic        transaction_hold,
    input  wire usc_token_t  token,
    input  wire usc_sof_t    sof,
    output logic [6:0]       device_address_field,
    output logic [10:0]      frame_number_field,
    output logic             token_accept
);

    logic [6:0]  next_address;
    logic [10:0] next_frame;
    logic        next_accept;

    // ------------------------------------------------------------------
    // Next values.
    // ------------------------------------------------------------------
    // Bus reset outranks a firmware write so the device falls back to zero.
    always_comb begin
        next_address = device_address_field;
        if (bus_reset_det) begin
            next_address = ADDRESS_RESET;
        end else if (addr_wr) begin
            next_address = addr_wdata;
        end
        next_frame = sof.valid ? sof.frame : frame_number_field;
        // Tokens stall while transactions are held so queued work drains first.
        next_accept = token.valid && (token.address == device_address_field)
                      && module_enable && !transaction_hold;
    end

    // ------------------------------------------------------------------
    // Registers.
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (reset) begin
            device_address_field <= ADDRESS_RESET;
            frame_number_field   <= FRAME_RESET;
            token_accept         <= 1'b0;
        end else if (ce) begin
            device_address_field <= next_address;
            frame_number_field   <= next_frame;
            token_accept         <= next_accept;
        end
    end

endmodule

`default_nettype wire

// ### src/usc_status_control.sv
// Top of the USB status and control block: status queue and window,
// control register, ping-pong bank bits of endpoints five and six, and
// the register read path. Address and frame logic sit in a submodule.
// Assumes all inputs come from logic on mclk; no synchronisers needed.
`default_nettype none

module usc_status_control
    import usc_pkg::*;
(
    input  wire logic         mclk,
    input  wire logic         reset,
    input  wire logic         ce,
    input  wire usc_reg_req_t reg_req,
    output logic [7:0]        reg_rdata,
    input  wire logic         xact_valid,
    input  wire usc_status_t  xact_status,
    output logic              queue_full,
    output logic              token_done_flag,
    input  wire logic         token_done_clear,
    input  wire logic         setup_rcvd,
    input  wire logic         bus_reset_det,
    input  wire usc_token_t   token,
    input  wire usc_sof_t     sof,
    output logic              token_accept,
    output logic              transaction_hold,
    output logic              remote_wakeup_drive,
    output logic              module_enable,
    input  wire logic [1:0]   bank_toggle,
    output logic [1:0]        pingpong_bank
);

    // ------------------------------------------------------------------
    // Declarations.
    // ------------------------------------------------------------------
    logic [1:0]  wr_ptr;
    logic [1:0]  rd_ptr;
    logic [2:0]  count;
    logic        head_ok;
    usc_status_t window;
    usc_status_t head_data;
    logic [1:0]  next_wr_ptr;
    logic [1:0]  next_rd_ptr;
    logic [2:0]  next_count;
    logic        next_head_ok;
    usc_status_t next_window;
    logic        next_flag;
    logic        next_queue_full;
    logic        push;
    logic        pop;

    logic        next_hold;
    logic        next_resume;
    logic        next_enable;
    logic [1:0]  next_bank;
    logic [7:0]  next_rdata;
    logic        ctl_wr;
    logic        bank_clear;
    logic        enable_set;
    logic [6:0]  device_address_field;
    logic [10:0] frame_number_field;

    assign ctl_wr = reg_req.wr && (reg_req.index == REG_CONTROL);

    // ------------------------------------------------------------------
    // Status queue and window.
    // ------------------------------------------------------------------
    // A finished descriptor is queued while count is below four; a full queue drops the entry and
    // queue_full lets the engine stall instead of losing status.
    always_comb begin
        push         = xact_valid && (count != QUEUE_FULL_CNT);
        pop          = !token_done_flag && head_ok;
        next_wr_ptr  = push ? wr_ptr + 2'd1 : wr_ptr;
        next_rd_ptr  = pop ? rd_ptr + 2'd1 : rd_ptr;
        next_count   = count + {2'b00, push} - {2'b00, pop};
        // Head data are good once the entry has sat a cycle at rd_ptr.
        next_head_ok = (count != 3'd0) && !pop;
        next_window  = pop ? head_data : window;
        next_flag    = token_done_flag;
        if (pop) begin
            next_flag = 1'b1;
        end else if (token_done_clear) begin
            next_flag = 1'b0;
        end
        next_queue_full = (next_count == QUEUE_FULL_CNT);
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            wr_ptr          <= 2'd0;
            rd_ptr          <= 2'd0;
            count           <= 3'd0;
            head_ok         <= 1'b0;
            window          <= '0;
            token_done_flag <= 1'b0;
            queue_full      <= 1'b0;
        end else if (ce) begin
            wr_ptr          <= next_wr_ptr;
            rd_ptr          <= next_rd_ptr;
            count           <= next_count;
            head_ok         <= next_head_ok;
            window          <= next_window;
            token_done_flag <= next_flag;
            queue_full      <= next_queue_full;
        end
    end

    usc_status_mem u_mem (
        .mclk    (mclk),
        .ce      (ce),
        .wr_en   (push),
        .wr_addr (wr_ptr),
        .wr_data (xact_status),
        .rd_addr (rd_ptr),
        .rd_data (head_data)
    );

    // ------------------------------------------------------------------
    // Control register and ping-pong bank bits.
    // ------------------------------------------------------------------
    // A setup token sets the hold bit even in the cycle software clears it,
    // so a second setup is never missed.
    always_comb begin
        bank_clear  = ctl_wr && reg_req.wdata[CTL_BANKCLR_BIT];
        enable_set  = ctl_wr && reg_req.wdata[CTL_ENABLE_BIT] && !module_enable;
        next_hold   = transaction_hold;
        if (setup_rcvd) begin
            next_hold = 1'b1;
        end else if (ctl_wr) begin
            next_hold = reg_req.wdata[CTL_HOLD_BIT];
        end
        next_resume = ctl_wr ? reg_req.wdata[CTL_RESUME_BIT] : remote_wakeup_drive;
        next_enable = ctl_wr ? reg_req.wdata[CTL_ENABLE_BIT] : module_enable;
        // Only endpoints five and six own bank bits, so the clear can reach no other.
        if (bank_clear || enable_set) begin
            next_bank = 2'b00;
        end else begin
            next_bank = pingpong_bank ^ bank_toggle;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            transaction_hold    <= CTL_RESET[CTL_HOLD_BIT];
            remote_wakeup_drive <= CTL_RESET[CTL_RESUME_BIT];
            module_enable       <= CTL_RESET[CTL_ENABLE_BIT];
            pingpong_bank       <= 2'b00;
        end else if (ce) begin
            transaction_hold    <= next_hold;
            remote_wakeup_drive <= next_resume;
            module_enable       <= next_enable;
            pingpong_bank       <= next_bank;
        end
    end

    // ------------------------------------------------------------------
    // Address and frame number.
    // ------------------------------------------------------------------
    usc_addr_frame u_addr_frame (
        .mclk                 (mclk),
        .reset                (reset),
        .ce                   (ce),
        .addr_wr              (reg_req.wr && (reg_req.index == REG_ADDRESS)),
        .addr_wdata           (reg_req.wdata[6:0]),
        .bus_reset_det        (bus_reset_det),
        .module_enable        (module_enable),
        .transaction_hold     (transaction_hold),
        .token                (token),
        .sof                  (sof),
        .device_address_field (device_address_field),
        .frame_number_field   (frame_number_field),
        .token_accept         (token_accept)
    );

    // ------------------------------------------------------------------
    // Register read path.
    // ------------------------------------------------------------------
    // Read data appear the cycle after the strobe and read zero otherwise;
    // the bank-clear bit is a strobe and always reads zero.
    always_comb begin
        next_rdata = 8'h00;
        if (reg_req.rd) begin
            case (reg_req.index)
                REG_STATUS: begin
                    next_rdata = usc_status_byte(window);
                end
                REG_CONTROL: begin
                    next_rdata = {2'b00, transaction_hold, 2'b00,
                                  remote_wakeup_drive, 1'b0, module_enable};
                end
                REG_ADDRESS: begin
                    next_rdata = {1'b0, device_address_field};
                end
                REG_FRAME_LOW: begin
                    next_rdata = frame_number_field[7:0];
                end
                REG_FRAME_HI: begin
                    next_rdata = {5'b00000, frame_number_field[10:8]};
                end
                default: begin
                    next_rdata = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            reg_rdata <= 8'h00;
        end else if (ce) begin
            reg_rdata <= next_rdata;
        end
    end

endmodule

`default_nettype wire

// ### tb/usc_monitor.sv
// Checker of the status and control block, bound to its top module.
// Assumes one clock domain; cycles with ce low are frozen and skipped.
`default_nettype none
module usc_monitor
    import usc_pkg::*;
(
    input wire logic         mclk,
    input wire logic         reset,
    input wire logic         ce,
    input wire usc_reg_req_t reg_req,
    input wire logic [7:0]   reg_rdata,
    input wire logic         xact_valid,
    input wire logic         token_done_flag,
    input wire logic         token_done_clear,
    input wire logic         setup_rcvd,
    input wire usc_token_t   token,
    input wire logic         token_accept,
    input wire logic         transaction_hold,
    input wire logic         remote_wakeup_drive,
    input wire logic         module_enable,
    input wire logic [1:0]   pingpong_bank
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    // A frozen cycle holds all state, so it is excluded rather than modelled.
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset || !ce);
    sequence s_ctl_wr;
        reg_req.wr && reg_req.index == REG_CONTROL;
    endsequence
    sequence s_push_idle;
        xact_valid && !token_done_flag;
    endsequence
    a_setup_hold: assert property (setup_rcvd |=> transaction_hold)
        else $error("setup did not set hold");
    a_hold_blocks: assert property (token.valid && transaction_hold |=> !token_accept)
        else $error("token accepted while held");
    a_accept_cause: assert property (token_accept |-> $past(token.valid && module_enable && !transaction_hold))
        else $error("token accepted without cause");
    a_bank_clear: assert property (s_ctl_wr ##0 reg_req.wdata[1] |=> pingpong_bank == 2'b00)
        else $error("bank bits not cleared");
    a_enable_clear: assert property (s_ctl_wr ##0 (reg_req.wdata[0] && !module_enable)
        |=> module_enable && pingpong_bank == 2'b00)
        else $error("enable did not clear banks");
    a_resume_track: assert property (s_ctl_wr |=> remote_wakeup_drive == $past(reg_req.wdata[2]))
        else $error("resume drive mismatch");
    a_flag_rise: assert property (s_push_idle |-> ##[1:4] token_done_flag)
        else $error("flag did not rise after push");
    a_flag_stands: assert property (token_done_flag && !token_done_clear |=> token_done_flag)
        else $error("flag dropped without clear");
    a_clear_drop: assert property (token_done_flag && token_done_clear |=> !token_done_flag)
        else $error("flag not dropped by clear");
    a_frame_hi_zero: assert property (reg_req.rd && reg_req.index == REG_FRAME_HI
        |=> reg_rdata[7:3] == 5'h00)
        else $error("frame high unused bits set");
endmodule

bind usc_status_control usc_monitor i_usc_monitor (.mclk(mclk), .reset(reset), .ce(ce), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .xact_valid(xact_valid), .token_done_flag(token_done_flag),
    .token_done_clear(token_done_clear), .setup_rcvd(setup_rcvd), .token(token), .token_accept(token_accept),
    .transaction_hold(transaction_hold), .remote_wakeup_drive(remote_wakeup_drive),
    .module_enable(module_enable), .pingpong_bank(pingpong_bank));
`default_nettype wire

// ### tb/usc_host_model.sv
// Host side of the bus as the block sees it: tokens, frames, bus events.
// Assumes the bench calls its tasks; signals change at the falling edge.
`default_nettype none
module usc_host_model
    import usc_pkg::*;
(
    input  wire logic mclk,
    output usc_token_t token,
    output usc_sof_t   sof,
    output logic       setup_rcvd,
    output logic       bus_reset_det
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------------
    // Bus events
    // ------------------------------------------------------------------
    // Idle fields show the inverse of the last value, so stale data never matches.
    initial begin
        token = {1'b0, 7'h7F};
        sof = {1'b0, 11'h7FF};
        setup_rcvd = 1'b0;
        bus_reset_det = 1'b0;
    end
    task automatic send_token(input logic [6:0] a);
        @(negedge mclk);
        token <= {1'b1, a};
        @(negedge mclk);
        token <= {1'b0, ~a};
    endtask
    task automatic send_sof(input logic [10:0] f);
        @(negedge mclk);
        sof <= {1'b1, f};
        @(negedge mclk);
        sof <= {1'b0, ~f};
    endtask
    // One task covers both single-cycle events: a setup token or a bus reset.
    task automatic pulse(input logic setup);
        @(negedge mclk);
        {setup_rcvd, bus_reset_det} <= {setup, ~setup};
        @(negedge mclk);
        {setup_rcvd, bus_reset_det} <= 2'b00;
    endtask
endmodule
`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench of the status and control block with a host model.
// Assumes the package, design and checker sources are compiled first.
`default_nettype none
module testbench
    import usc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------------
    logic         mclk, reset, ce, xact_valid, token_done_clear, queue_full, token_done_flag, token_accept;
    logic         transaction_hold, remote_wakeup_drive, module_enable, setup_rcvd, bus_reset_det;
    logic [1:0]   bank_toggle, pingpong_bank;
    logic [7:0]   reg_rdata;
    usc_reg_req_t reg_req;
    usc_status_t  xact_status;
    usc_token_t   token;
    usc_sof_t     sof;
    int           fails, num_checks;
    usc_host_model i_usc_host_model (.mclk(mclk), .token(token), .sof(sof), .setup_rcvd(setup_rcvd),
        .bus_reset_det(bus_reset_det));
    usc_status_control i_usc_status_control (.mclk(mclk), .reset(reset), .ce(ce), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .xact_valid(xact_valid), .xact_status(xact_status), .queue_full(queue_full),
        .token_done_flag(token_done_flag), .token_done_clear(token_done_clear), .setup_rcvd(setup_rcvd),
        .bus_reset_det(bus_reset_det), .token(token), .sof(sof), .token_accept(token_accept),
        .transaction_hold(transaction_hold), .remote_wakeup_drive(remote_wakeup_drive),
        .module_enable(module_enable), .bank_toggle(bank_toggle), .pingpong_bank(pingpong_bank));
    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks=%0d mismatches=%0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic wr_reg(input logic [2:0] idx, input logic [7:0] d);
        @(negedge mclk);
        reg_req <= {idx, 1'b0, 1'b1, d};
        @(negedge mclk);
        reg_req <= '0;
    endtask
    // Read data is registered, so it is judged one cycle after the strobe.
    task automatic rd_reg(input logic [2:0] idx, input logic [7:0] exp);
        @(negedge mclk);
        reg_req <= {idx, 1'b1, 1'b0, 8'h00};
        @(negedge mclk);
        reg_req <= '0;
        chk(reg_rdata, exp);
    endtask
    // Valid stays high across a run, so pushes land on consecutive edges.
    task automatic push_run(input int first, input int last);
        int k;
        @(negedge mclk);
        for (k = first; k <= last; k++) begin
            xact_valid <= 1'b1;
            xact_status <= {k[3:0], k[0], k[1]};
            @(negedge mclk);
        end
        xact_valid <= 1'b0;
    endtask
    task automatic wait_flag();
        int i;
        for (i = 0; i < 8 && token_done_flag !== 1'b1; i++)
            @(negedge mclk);
        if (token_done_flag !== 1'b1) begin
            fails++;
            stop_test();
        end
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        int i;
        @(negedge mclk);
        reset <= 1'b1;
        repeat (16) @(negedge mclk);
        reset <= 1'b0;
        for (i = 0; i < 6; i++)
            rd_reg(i[2:0], 8'h00);
        $display("reset test done");
    endtask
    // Fill window and queue, push once more into a full queue, then drain.
    task automatic t_queue();
        int k;
        push_run(0, 0);
        wait_flag();
        push_run(1, 5);
        chk(queue_full, 1'b1);
        for (k = 0; k <= 4; k++) begin
            chk(token_done_flag, 1'b1);
            rd_reg(REG_STATUS, {k[3:0], k[0], k[1], 2'b00});
            token_done_clear <= 1'b1;
            @(negedge mclk);
            token_done_clear <= 1'b0;
            chk(token_done_flag, 1'b0);
            if (k < 4)
                wait_flag();
        end
        repeat (4) @(negedge mclk);
        chk(token_done_flag, 1'b0);
        chk(queue_full, 1'b0);
        push_run(6, 6);
        wait_flag();
        rd_reg(REG_STATUS, 8'h64);
        $display("queue test done");
    endtask
    task automatic t_control();
        wr_reg(REG_CONTROL, 8'h01);
        bank_toggle <= 2'b11;
        @(negedge mclk);
        bank_toggle <= 2'b00;
        chk(pingpong_bank, 2'b11);
        wr_reg(REG_CONTROL, 8'h00);
        wr_reg(REG_CONTROL, 8'h01);
        chk({module_enable, pingpong_bank}, 3'h4);
        bank_toggle <= 2'b01;
        @(negedge mclk);
        bank_toggle <= 2'b00;
        wr_reg(REG_CONTROL, 8'h03);
        chk(pingpong_bank, 2'b00);
        wr_reg(REG_CONTROL, 8'hFF);
        chk({transaction_hold, remote_wakeup_drive}, 2'b11);
        rd_reg(REG_CONTROL, 8'h25);
        wr_reg(REG_CONTROL, 8'h01);
        chk({transaction_hold, remote_wakeup_drive}, 2'b00);
        $display("control test done");
    endtask
    task automatic t_address();
        wr_reg(REG_ADDRESS, 8'hFF);
        rd_reg(REG_ADDRESS, 8'h7F);
        wr_reg(REG_ADDRESS, 8'h2A);
        i_usc_host_model.send_token(7'h2A);
        chk(token_accept, 1'b1);
        i_usc_host_model.send_token(7'h2B);
        chk(token_accept, 1'b0);
        i_usc_host_model.pulse(1'b1);
        chk(transaction_hold, 1'b1);
        i_usc_host_model.send_token(7'h2A);
        chk(token_accept, 1'b0);
        wr_reg(REG_CONTROL, 8'h01);
        i_usc_host_model.send_token(7'h2A);
        chk(token_accept, 1'b1);
        wr_reg(REG_CONTROL, 8'h00);
        i_usc_host_model.send_token(7'h2A);
        chk(token_accept, 1'b0);
        wr_reg(REG_CONTROL, 8'h01);
        i_usc_host_model.pulse(1'b0);
        rd_reg(REG_ADDRESS, 8'h00);
        i_usc_host_model.send_token(7'h00);
        chk(token_accept, 1'b1);
        $display("address test done");
    endtask
    task automatic t_frame();
        i_usc_host_model.send_sof(11'h5A3);
        rd_reg(REG_FRAME_LOW, 8'hA3);
        rd_reg(REG_FRAME_HI, 8'h05);
        i_usc_host_model.send_sof(11'h7FF);
        rd_reg(REG_FRAME_LOW, 8'hFF);
        rd_reg(REG_FRAME_HI, 8'h07);
        wr_reg(REG_FRAME_LOW, 8'h00);
        rd_reg(REG_FRAME_LOW, 8'hFF);
        wr_reg(3'h5, 8'hFF);
        rd_reg(3'h5, 8'h00);
        wr_reg(REG_ADDRESS, 8'h15);
        $display("frame test done");
    endtask
    // Low ce must freeze everything: a write, a frame and a clear all go unseen.
    task automatic t_freeze();
        @(negedge mclk);
        ce <= 1'b0;
        wr_reg(REG_ADDRESS, 8'h33);
        i_usc_host_model.send_sof(11'h123);
        token_done_clear <= 1'b1;
        @(negedge mclk);
        token_done_clear <= 1'b0;
        ce <= 1'b1;
        chk(token_done_flag, 1'b1);
        rd_reg(REG_ADDRESS, 8'h15);
        rd_reg(REG_FRAME_LOW, 8'hFF);
        $display("freeze test done");
    endtask
    // ------------------------------------------------------------------
    // Clock, watchdog and main sequence
    // ------------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        repeat (20000) @(posedge mclk);
        fails++;
        stop_test();
    end
    initial begin
        {ce, reset, xact_valid, token_done_clear} = 4'hC;
        reg_req = '0;
        xact_status = '0;
        bank_toggle = 2'b00;
        fails = 0;
        num_checks = 0;
        t_reset();
        t_queue();
        t_control();
        t_address();
        t_frame();
        t_freeze();
        t_reset();
        stop_test();
    end
endmodule
`default_nettype wire
